/* File: mmb_bank_decoder.sv */
/*
 * Program counter and banked data memory decoder of the 8-bit core, with the
 * core special registers, general storage and a request port to peripherals.
 * Assumes all inputs come from core logic on clk_sys_in and peripherals answer
 * a registered read request combinationally on periph_rdata_in.
 */
`timescale 1ns/1ps

module mmb_bank_decoder (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic fetch_next_in,
    input wire logic jump_in,
    input wire logic [12:0] jump_target_in,
    input wire logic irq_take_in,
    input wire mmb_pkg::mmb_data_req_type data_req_in,
    input wire logic flags_we_in,
    input wire logic [2:0] flags_in,
    input wire logic [7:0] periph_rdata_in,
    output logic [12:0] pc_out,
    output logic [10:0] prog_addr_out,
    output logic [7:0] data_rdata_out,
    output logic data_rvalid_out,
    output logic [1:0] bank_out,
    output mmb_pkg::mmb_periph_req_type periph_req_out
);
    import mmb_pkg::*;

    logic [12:0] pc_reg;
    logic [12:0] pc_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] indirect_pointer_reg;
    logic [7:0] indirect_pointer_next;
    logic [7:0] program_counter_high_latch_reg;
    logic [7:0] program_counter_high_latch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    mmb_periph_req_type periph_reg;
    mmb_periph_req_type periph_next;

    logic indirect;
    logic [8:0] eff_addr;
    mmb_region_type region;
    logic [6:0] gpr_idx;
    logic [7:0] gpr_rdata;
    logic gpr_we;
    logic pc_low_wr;
    logic [7:0] local_rdata;

    // ==========================================================
    // Address decode
    always_comb begin
        indirect = (data_req_in.addr == ADDR_INDIRECT);
        if (indirect) begin
            eff_addr = {status_reg[IND_BANK_BIT], indirect_pointer_reg};
        end else begin
            eff_addr = {status_reg[BANK_HI_BIT:BANK_LO_BIT], data_req_in.addr};
        end
        region = mmb_decode(eff_addr, indirect);
        gpr_idx = mmb_gpr_index(eff_addr[7:0]);
        gpr_we = data_req_in.wr && (region == REG_GPR);
        pc_low_wr = data_req_in.wr && (region == REG_PC_LOW);
    end

    // ==========================================================
    // General storage
    mmb_gpr_store mmb_gpr_store_inst (
        .clk_sys_in(clk_sys_in),
        .we_in(gpr_we),
        .idx_in(gpr_idx),
        .wdata_in(data_req_in.wdata),
        .rdata_out(gpr_rdata)
    );

    // ==========================================================
    // Program counter
    always_comb begin
        if (irq_take_in) begin
            pc_next = IRQ_VEC;
        end else if (pc_low_wr) begin
            pc_next = {program_counter_high_latch_reg[4:0], data_req_in.wdata};
        end else if (jump_in) begin
            pc_next = jump_target_in;
        end else if (fetch_next_in) begin
            pc_next = 13'(pc_reg + PC_STEP);
        end else begin
            pc_next = pc_reg;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            pc_reg <= RESET_VEC;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // Fetch uses the low 11 bits only, so high addresses wrap
    assign pc_out = pc_reg;
    assign prog_addr_out = pc_reg[10:0];

    // ==========================================================
    // Core registers and read path
    always_comb begin
        status_next = status_reg;
        indirect_pointer_next = indirect_pointer_reg;
        program_counter_high_latch_next = program_counter_high_latch_reg;
        if (data_req_in.wr) begin
            case (region)
                REG_STATUS: status_next = data_req_in.wdata;
                REG_POINTER: indirect_pointer_next = data_req_in.wdata;
                REG_PC_LATCH: program_counter_high_latch_next = data_req_in.wdata & PC_LATCH_MASK;
                default: begin
                end
            endcase
        end
        // Core result flags win over a software write in the same cycle
        if (flags_we_in) begin
            status_next[2:0] = flags_in;
        end

        case (region)
            REG_PC_LOW: local_rdata = pc_reg[7:0];
            REG_STATUS: local_rdata = status_reg;
            REG_POINTER: local_rdata = indirect_pointer_reg;
            REG_PC_LATCH: local_rdata = program_counter_high_latch_reg;
            REG_GPR: local_rdata = gpr_rdata;
            default: local_rdata = ZERO_BYTE;
        endcase

        periph_next.rd = data_req_in.rd && (region == REG_PERIPH);
        periph_next.wr = data_req_in.wr && (region == REG_PERIPH);
        periph_next.addr = eff_addr[7:0];
        periph_next.wdata = data_req_in.wdata;

        // A peripheral answer arrives one cycle later and takes the slot
        rvalid_next = periph_reg.rd || (data_req_in.rd && (region != REG_PERIPH));
        if (periph_reg.rd) begin
            rdata_next = periph_rdata_in;
        end else if (data_req_in.rd && (region != REG_PERIPH)) begin
            rdata_next = local_rdata;
        end else begin
            rdata_next = rdata_reg;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            status_reg <= STATUS_RESET;
            indirect_pointer_reg <= POINTER_RESET;
            program_counter_high_latch_reg <= PC_LATCH_RESET;
            rdata_reg <= ZERO_BYTE;
            rvalid_reg <= 1'b0;
            periph_reg <= '0;
        end else begin
            status_reg <= status_next;
            indirect_pointer_reg <= indirect_pointer_next;
            program_counter_high_latch_reg <= program_counter_high_latch_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            periph_reg <= periph_next;
        end
    end

    assign data_rdata_out = rdata_reg;
    assign data_rvalid_out = rvalid_reg;
    assign bank_out = status_reg[BANK_HI_BIT:BANK_LO_BIT];
    assign periph_req_out = periph_reg;

    // ==========================================================
    // Checks
    chk_reset_vector: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        $rose(nrst_in) |-> (pc_reg == RESET_VEC) && (prog_addr_out == 11'h000))
        else $error("pc not at reset vector after reset");

    chk_irq_vector: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        irq_take_in |=> (pc_reg == IRQ_VEC) && (prog_addr_out == 11'h004))
        else $error("interrupt did not continue at its vector");

    chk_fetch_wrap: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (fetch_next_in && !irq_take_in && !jump_in && !pc_low_wr && pc_reg[10:0] == PROG_LAST)
        |=> (prog_addr_out == 11'h000) && (pc_reg[12:11] == $past(pc_reg[12:11]) + 2'h1))
        else $error("fetch did not wrap inside program store");

    chk_both_buses: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (fetch_next_in && !irq_take_in && !jump_in && !pc_low_wr && !periph_reg.rd
        && data_req_in.rd && region != REG_PERIPH)
        |=> data_rvalid_out && (pc_reg == 13'($past(pc_reg) + PC_STEP)))
        else $error("fetch and data access not served in one cycle");

    chk_bank_unimpl: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (data_req_in.rd && !periph_reg.rd && data_req_in.addr >= 7'h40
        && status_reg[BANK_HI_BIT:BANK_LO_BIT] == BANK1_SEL)
        |=> data_rvalid_out && (data_rdata_out == 8'h00))
        else $error("bank 1 upper location did not read zero");

    chk_status_mirror: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (data_req_in.wr && data_req_in.addr == ADDR_STATUS && !status_reg[BANK_HI_BIT] && !flags_we_in)
        |=> status_reg == $past(data_req_in.wdata))
        else $error("status write not seen in shared register");

    chk_gpr_readback: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ((data_req_in.wr && region == REG_GPR)
        ##1 (data_req_in.rd && !periph_reg.rd && region == REG_GPR && eff_addr == $past(eff_addr)))
        |=> data_rdata_out == $past(data_req_in.wdata, 2))
        else $error("general storage did not return written byte");

    chk_unimpl_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (data_req_in.rd && !periph_reg.rd && region == REG_NONE)
        |=> data_rvalid_out && (data_rdata_out == 8'h00))
        else $error("unimplemented location did not read zero");

    chk_special_periph: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (data_req_in.rd && !eff_addr[8] && eff_addr[6:0] > ADDR_PC_LATCH && eff_addr[6:0] <= SPECIAL_TOP)
        |=> periph_req_out.rd && (periph_req_out.addr == $past(eff_addr[7:0])) ##1 data_rvalid_out)
        else $error("low location not routed to peripheral registers");

    chk_indirect_path: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (data_req_in.rd && !periph_reg.rd && indirect && indirect_pointer_reg[6:0] == ADDR_POINTER
        && !status_reg[IND_BANK_BIT])
        |=> data_rdata_out == $past(indirect_pointer_reg))
        else $error("indirect read did not follow the pointer");

endmodule

/* File: mmb_pkg.sv */
/*
 * Shared constants, carrier structs and decode functions for the memory map
 * and bank decoder of the 8-bit core.
 * Assumes a single 50 MHz core clock and a core that issues at most one data
 * request per cycle.
 */
package mmb_pkg;

    // ==========================================================
    // Program store
    localparam logic [12:0] RESET_VEC = 13'h0000;
    localparam logic [12:0] IRQ_VEC = 13'h0004;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam logic [10:0] PROG_LAST = 11'h7FF;

    // ==========================================================
    // Data map, offsets within a bank
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_PC_LOW = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_POINTER = 7'h04;
    localparam logic [6:0] ADDR_PC_LATCH = 7'h0A;
    localparam logic [6:0] SPECIAL_TOP = 7'h1F;
    localparam logic [7:0] GPR0_LO = 8'h20;
    localparam logic [7:0] GPR1_LO = 8'hA0;
    localparam logic [7:0] GPR1_HI = 8'hBF;
    localparam logic [6:0] GPR0_COUNT = 7'h60;
    localparam int GPR_DEPTH = 128;

    // ==========================================================
    // Core status fields and reset values
    localparam int IND_BANK_BIT = 7;
    localparam int BANK_HI_BIT = 6;
    localparam int BANK_LO_BIT = 5;
    localparam logic [1:0] BANK1_SEL = 2'h1;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] PC_LATCH_RESET = 8'h00;
    localparam logic [7:0] PC_LATCH_MASK = 8'h1F;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mmb_data_req_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mmb_periph_req_type;

    typedef enum logic [7:0] {
        REG_NONE = 8'h01,
        REG_INDIRECT = 8'h02,
        REG_PC_LOW = 8'h04,
        REG_STATUS = 8'h08,
        REG_POINTER = 8'h10,
        REG_PC_LATCH = 8'h20,
        REG_GPR = 8'h40,
        REG_PERIPH = 8'h80
    } mmb_region_type;

    // ==========================================================
    // Decode of a 9-bit {bank, offset} data address
    function automatic mmb_region_type mmb_decode(input logic [8:0] a, input logic ind);
        mmb_region_type r;
        r = REG_NONE;
        if (!a[8]) begin
            case (a[6:0])
                ADDR_INDIRECT: r = ind ? REG_NONE : REG_INDIRECT;
                ADDR_PC_LOW: r = REG_PC_LOW;
                ADDR_STATUS: r = REG_STATUS;
                ADDR_POINTER: r = REG_POINTER;
                ADDR_PC_LATCH: r = REG_PC_LATCH;
                default: begin
                    if (a[6:0] <= SPECIAL_TOP) begin
                        r = REG_PERIPH;
                    end else if (!a[7] || a[7:0] <= GPR1_HI) begin
                        r = REG_GPR;
                    end else begin
                        r = REG_NONE;
                    end
                end
            endcase
        end
        return r;
    endfunction

    // Bank 0 storage first, bank 1 storage packed after it
    function automatic logic [6:0] mmb_gpr_index(input logic [7:0] a);
        logic [6:0] idx;
        if (a[7]) begin
            idx = 7'(GPR0_COUNT + (a[6:0] - GPR1_LO[6:0]));
        end else begin
            idx = 7'(a[6:0] - GPR0_LO[6:0]);
        end
        return idx;
    endfunction

endpackage

/* File: mmb_gpr_store.sv */
/*
 * General-purpose data storage: 128 bytes of flip-flops, index addressed.
 * Assumes the caller only writes with an index inside the storage; read is
 * combinational so the caller registers it.
 */
`timescale 1ns/1ps

module mmb_gpr_store (
    input wire logic clk_sys_in,
    input wire logic we_in,
    input wire logic [6:0] idx_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    import mmb_pkg::*;

    logic [7:0] mem_reg [GPR_DEPTH];

    // ==========================================================
    // Storage, contents undefined after reset like static RAM
    always_ff @(posedge clk_sys_in) begin
        if (we_in) begin
            mem_reg[idx_in] <= wdata_in;
        end
    end

    assign rdata_out = mem_reg[idx_in];

endmodule

/* File: mmb_periph_model.sv */
/*
 * Peripheral register model on the far side of the decoder's peripheral port.
 * Assumes a registered one-cycle request and answers reads combinationally.
 */
`timescale 1ns/1ps

module mmb_periph_model (
    input wire logic clk_sys_in,
    input wire mmb_pkg::mmb_periph_req_type periph_req_in,
    output logic [7:0] periph_rdata_out
);
    import mmb_pkg::*;
    logic [7:0] mem_reg [0:255];
    logic [7:0] last_reg = 8'h00;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_reg[i] = 8'(i) ^ 8'hA5;
        end
    end
    always @(posedge clk_sys_in) begin
        if (periph_req_in.wr) begin
            mem_reg[periph_req_in.addr] <= periph_req_in.wdata;
        end
        if (periph_req_in.rd) begin
            last_reg <= mem_reg[periph_req_in.addr];
        end
    end
    // Released bus shows the inverse of the last answer
    assign periph_rdata_out = periph_req_in.rd ? mem_reg[periph_req_in.addr] : ~last_reg;
endmodule

/* File: mmb_bank_decoder_test.sv */
/*
 * Self-checking bench for the bank decoder: map table, program counter,
 * indirect access, peripheral port, unimplemented banks and reset.
 * Assumes mmb_pkg, mmb_bank_decoder and mmb_periph_model are compiled first.
 */
`timescale 1ns/1ps

module mmb_bank_decoder_test;
    import mmb_pkg::*;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e; logic b;} mmb_row_type;
    logic clk_sys_in = 1'h0;
    logic nrst_in = 1'h0;
    logic fetch_next_in = 1'h0;
    logic jump_in = 1'h0;
    logic [12:0] jump_target_in = 13'h0000;
    logic irq_take_in = 1'h0;
    mmb_data_req_type data_req_in = '0;
    logic flags_we_in = 1'h0;
    logic [2:0] flags_in = 3'h0;
    logic [7:0] periph_rdata_in;
    logic [12:0] pc_out;
    logic [10:0] prog_addr_out;
    logic [7:0] data_rdata_out;
    logic data_rvalid_out;
    logic [1:0] bank_out;
    mmb_periph_req_type periph_req_out;
    int mismatches = 0;
    int checks_done = 0;
    logic cur_bank = 1'h0;
    mmb_row_type rows [12];

    mmb_bank_decoder mmb_bank_decoder_inst (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .fetch_next_in(fetch_next_in), .jump_in(jump_in),
        .jump_target_in(jump_target_in), .irq_take_in(irq_take_in), .data_req_in(data_req_in),
        .flags_we_in(flags_we_in), .flags_in(flags_in), .periph_rdata_in(periph_rdata_in), .pc_out(pc_out),
        .prog_addr_out(prog_addr_out), .data_rdata_out(data_rdata_out), .data_rvalid_out(data_rvalid_out),
        .bank_out(bank_out), .periph_req_out(periph_req_out)
    );
    mmb_periph_model mmb_periph_model_inst (
        .clk_sys_in(clk_sys_in), .periph_req_in(periph_req_out), .periph_rdata_out(periph_rdata_in)
    );

    always #10 clk_sys_in = ~clk_sys_in;

    // ==========================================================
    // Bench tasks
    task automatic chk(input string n, input logic [17:0] seen, input logic [17:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic tick;
        @(posedge clk_sys_in);
        #1;
    endtask

    // One data access, then an idle cycle
    task automatic acc(input logic rd, input logic wr, input logic [6:0] a, input logic [7:0] d,
                       input logic per, input logic [7:0] e);
        data_req_in = {rd, wr, a, d};
        tick();
        data_req_in = '0;
        if (per) begin
            chk("periph_req", periph_req_out, {rd, wr, cur_bank, a, d});
            if (rd) begin
                tick();
            end
        end
        if (rd) begin
            chk("rvalid", data_rvalid_out, 1'h1);
            chk("rdata", data_rdata_out, e);
        end
        tick();
    endtask

    task automatic put(input logic [6:0] a, input logic [7:0] d);
        acc(1'h0, 1'h1, a, d, 1'h0, 8'h00);
    endtask

    task automatic get(input logic [6:0] a, input logic [7:0] e);
        acc(1'h1, 1'h0, a, 8'h00, 1'h0, e);
    endtask

    task automatic pc_op(input logic f, input logic j, input logic [12:0] t, input logic i, input logic [12:0] e);
        fetch_next_in = f;
        jump_in = j;
        jump_target_in = t;
        irq_take_in = i;
        tick();
        fetch_next_in = 1'h0;
        jump_in = 1'h0;
        irq_take_in = 1'h0;
        chk("pc", pc_out, e);
        chk("prog_addr", prog_addr_out, e[10:0]);
        tick();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rows = '{'{7'h03, 8'h18, 8'h18, 1'h0}, '{7'h20, 8'hAA, 8'hAA, 1'h0}, '{7'h7F, 8'h5A, 8'h5A, 1'h0},
                 '{7'h04, 8'h3C, 8'h3C, 1'h0}, '{7'h0A, 8'hFF, 8'h1F, 1'h0}, '{7'h03, 8'h38, 8'h38, 1'h1},
                 '{7'h20, 8'h11, 8'h11, 1'h1}, '{7'h3F, 8'h22, 8'h22, 1'h1}, '{7'h40, 8'h33, 8'h00, 1'h1},
                 '{7'h7F, 8'h44, 8'h00, 1'h1}, '{7'h04, 8'h5E, 8'h5E, 1'h1}, '{7'h03, 8'h18, 8'h18, 1'h0}};
        repeat (5) tick();
        nrst_in = 1'h1;
        chk("pc", pc_out, RESET_VEC);
        chk("bank", bank_out, 2'h0);
        chk("rvalid", data_rvalid_out, 1'h0);
        get(ADDR_STATUS, STATUS_RESET);
        get(ADDR_POINTER, POINTER_RESET);
        get(ADDR_PC_LATCH, PC_LATCH_RESET);
        foreach (rows[k]) begin
            put(rows[k].a, rows[k].d);
            get(rows[k].a, rows[k].e);
            chk("bank", bank_out, {1'h0, rows[k].b});
        end
        pc_op(1'h1, 1'h0, 13'h0000, 1'h0, 13'h0001);
        pc_op(1'h0, 1'h1, 13'h07FF, 1'h0, 13'h07FF);
        pc_op(1'h1, 1'h0, 13'h0000, 1'h0, 13'h0800);
        pc_op(1'h0, 1'h1, 13'h1FFF, 1'h0, 13'h1FFF);
        pc_op(1'h1, 1'h0, 13'h0000, 1'h0, 13'h0000);
        pc_op(1'h1, 1'h1, 13'h0123, 1'h1, IRQ_VEC);
        put(ADDR_PC_LATCH, 8'h05);
        put(ADDR_PC_LOW, 8'h34);
        chk("pc", pc_out, 13'h0534);
        // Fetch step and data read in the same cycle
        data_req_in = {1'h1, 1'h0, ADDR_PC_LOW, 8'h00};
        fetch_next_in = 1'h1;
        tick();
        data_req_in = '0;
        fetch_next_in = 1'h0;
        chk("rdata", data_rdata_out, 8'h34);
        chk("pc", pc_out, 13'h0535);
        tick();
        // Write then read back with no idle cycle between
        data_req_in = {1'h0, 1'h1, 7'h21, 8'h6B};
        tick();
        data_req_in = {1'h1, 1'h0, 7'h21, 8'h00};
        tick();
        data_req_in = '0;
        chk("rvalid", data_rvalid_out, 1'h1);
        chk("rdata", data_rdata_out, 8'h6B);
        tick();
        put(ADDR_POINTER, 8'h84);
        get(ADDR_INDIRECT, 8'h84);
        put(ADDR_POINTER, 8'h20);
        get(ADDR_INDIRECT, 8'hAA);
        put(ADDR_INDIRECT, 8'h77);
        get(7'h20, 8'h77);
        get(7'h7F, 8'h5A);
        put(ADDR_POINTER, 8'hA0);
        get(ADDR_INDIRECT, 8'h11);
        put(ADDR_POINTER, 8'h00);
        get(ADDR_INDIRECT, 8'h00);
        acc(1'h0, 1'h1, 7'h0B, 8'h5C, 1'h1, 8'h00);
        acc(1'h1, 1'h0, 7'h0B, 8'h00, 1'h1, 8'h5C);
        cur_bank = 1'h1;
        put(ADDR_STATUS, 8'h38);
        acc(1'h1, 1'h0, 7'h0B, 8'h00, 1'h1, 8'h8B ^ 8'hA5);
        // Unimplemented bank, left again through the pointer
        put(ADDR_POINTER, 8'h03);
        put(ADDR_STATUS, 8'h58);
        chk("bank", bank_out, 2'h2);
        get(ADDR_STATUS, 8'h00);
        put(7'h20, 8'hEE);
        get(ADDR_INDIRECT, 8'h58);
        flags_we_in = 1'h1;
        flags_in = 3'h5;
        put(ADDR_INDIRECT, 8'h18);
        flags_we_in = 1'h0;
        get(7'h20, 8'h77);
        get(ADDR_STATUS, 8'h1D);
        // Indirect bank bit set points past the implemented banks
        put(ADDR_STATUS, 8'h98);
        get(ADDR_STATUS, 8'h98);
        get(ADDR_INDIRECT, 8'h00);
        nrst_in = 1'h0;
        tick();
        nrst_in = 1'h1;
        chk("pc", pc_out, RESET_VEC);
        chk("bank", bank_out, 2'h0);
        get(ADDR_STATUS, STATUS_RESET);
        get(ADDR_POINTER, POINTER_RESET);
        end_of_test();
    end

    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
endmodule
